// ==== src/par_readout.sv ====
// Per-port converter result registers with APB access and completion interrupt
`timescale 1ns/10ps

module par_readout #(
  parameter int NPORT = par_pkg::NUM_PORTS
) (
  // Clock and reset
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  // APB slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [7:0]                             paddr,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  // Converter side, same clock
  input  wire logic [NPORT-1:0]                       cur_start,
  input  wire logic [NPORT-1:0]                       cur_done,
  input  wire logic [NPORT-1:0]                       temp_start,
  input  wire logic [NPORT-1:0]                       temp_done,
  input  wire logic [par_pkg::RESULT_BITS-1:0]        conv_result,
  // Interrupt
  output logic                                        irq
);
  import par_pkg::*;

  // ****************************************************************
  // Result storage
  // ****************************************************************
  logic [RESULT_BITS-1:0] cur_val  [NPORT];
  logic [RESULT_BITS-1:0] temp_val [NPORT];
  logic [NPORT-1:0]       cur_flag;
  logic [NPORT-1:0]       temp_flag;
  logic [7:0]             irq_status;
  logic [7:0]             irq_mask;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cur_val[g]   <= '0;
          temp_val[g]  <= '0;
          cur_flag[g]  <= 1'b0;
          temp_flag[g] <= 1'b0;
        end else begin
          if (cur_start[g]) begin
            cur_flag[g] <= 1'b0;
          end else if (cur_done[g]) begin
            cur_flag[g] <= 1'b1;
            cur_val[g]  <= conv_result;
          end
          if (temp_start[g]) begin
            temp_flag[g] <= 1'b0;
          end else if (temp_done[g]) begin
            temp_flag[g] <= 1'b1;
            temp_val[g]  <= conv_result;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic [3:0]            sel_code  = paddr[SEL_LSB +: 4];
  wire logic [PORT_BITS-1:0]  port_code = paddr[PORT_LSB +: PORT_BITS];
  wire logic                  port_ok   = 32'(port_code) < NPORT;
  wire logic                  is_result = sel_code >= SEL_CURRENT_LOW && sel_code <= SEL_TEMP_HIGH;
  wire logic                  is_irq    = sel_code == SEL_IRQ_STATUS || sel_code == SEL_IRQ_MASK;
  wire logic                  hit       = (is_result && port_ok) || (is_irq && port_code == '0);
  wire logic                  addr_ok   = hit && paddr[1:0] == 2'h0;
  wire logic                  access    = psel && penable && pready;
  wire logic                  wr_irq    = access && pwrite && addr_ok && port_code == '0;

  wire logic [RESULT_BITS-1:0] cv = cur_val[port_code];
  wire logic [RESULT_BITS-1:0] tv = temp_val[port_code];
  logic [7:0] rd_byte;
  always_comb begin
    case (sel_code)
      SEL_CURRENT_LOW:  rd_byte = cv[7:0];
      SEL_CURRENT_HIGH: rd_byte = {cur_flag[port_code], cv[14:8]};
      SEL_TEMP_LOW:     rd_byte = tv[7:0];
      SEL_TEMP_HIGH:    rd_byte = {temp_flag[port_code], tv[14:8]};
      SEL_IRQ_STATUS:   rd_byte = irq_status;
      SEL_IRQ_MASK:     rd_byte = irq_mask;
      default:          rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // Interrupt: low nibble current done, high nibble temperature done
  // ****************************************************************
  logic [7:0] ev;
  always_comb begin
    ev = 8'h00;
    ev[NPORT-1:0] = cur_done & ~cur_start;
    ev[4 +: NPORT] = temp_done & ~temp_start;
  end
  wire logic write_status = wr_irq && sel_code == SEL_IRQ_STATUS;
  wire logic write_mask   = wr_irq && sel_code == SEL_IRQ_MASK;
  wire logic [7:0] next_status = ev | (irq_status & ~(write_status ? pwdata[7:0] : 8'h00));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 8'h00;
      irq_mask   <= IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (write_mask) irq_mask <= pwdata[7:0];
      irq        <= |(next_status & irq_mask);
    end
  end

  // ****************************************************************
  // APB response: no wait states, ready in the first access cycle, read data registered
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr <= psel && !penable && (!addr_ok || (pwrite && !is_irq));
    end
  end
endmodule : par_readout

// ==== src/par_pkg.sv ====
// Constants for the per-port converter result readout block
package par_pkg;
  // ****************************************************************
  // Register selects (indices, byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] SEL_CURRENT_LOW  = 4'ha;
  localparam logic [3:0] SEL_CURRENT_HIGH = 4'hb;
  localparam logic [3:0] SEL_TEMP_LOW     = 4'hc;
  localparam logic [3:0] SEL_TEMP_HIGH    = 4'hd;
  localparam logic [3:0] SEL_IRQ_STATUS   = 4'he;
  localparam logic [3:0] SEL_IRQ_MASK     = 4'hf;
  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int         SEL_LSB          = 2;
  localparam int         PORT_LSB         = 6;
  localparam int         PORT_BITS        = 2;
  localparam int         NUM_PORTS        = 4;
  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         DONE_BIT         = 7;
  localparam int         RESULT_BITS      = 15;
  localparam logic [7:0] RESULT_RESET     = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET   = 8'h00;
endpackage : par_pkg

// ==== sim/par_readout_chk.sv ====
// Assertions on the result readout ports
`timescale 1ns/10ps
module par_chk #(parameter int NPORT = 4) (
  // Clock, reset and APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Converter
  input wire logic [NPORT-1:0] cur_start,
  input wire logic [NPORT-1:0] cur_done,
  input wire logic [NPORT-1:0] temp_start,
  input wire logic [NPORT-1:0] temp_done,
  input wire logic [14:0]      conv_result
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_ro; pready && pwrite && paddr[5:2] inside {[4'ha:4'hd]} |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("write accepted");
  property p_cur_clr; rd && paddr == 8'h2c && $past(cur_start[0], 2) |-> !prdata[7]; endproperty
  a_cur_clr: assert property (p_cur_clr) else $error("flag set");
  property p_cur_set; rd && paddr == 8'h2c && $past(cur_done[0], 2)
    |-> prdata == {24'h0, 1'b1, $past(conv_result[14:8], 2)}; endproperty
  a_cur_set: assert property (p_cur_set) else $error("bad high");
  property p_tmp_clr; rd && paddr == 8'h34 && $past(temp_start[0], 2) |-> !prdata[7]; endproperty
  a_tmp_clr: assert property (p_tmp_clr) else $error("flag set");
  property p_tmp_set; rd && paddr == 8'h34 && $past(temp_done[0], 2)
    |-> prdata == {24'h0, 1'b1, $past(conv_result[14:8], 2)}; endproperty
  a_tmp_set: assert property (p_tmp_set) else $error("bad high");
  property p_tmp_lo; rd && paddr == 8'h30 && $past(temp_done[0], 2)
    |-> prdata == {24'h0, $past(conv_result[7:0], 2)}; endproperty
  a_tmp_lo: assert property (p_tmp_lo) else $error("bad low");
  property p_cur_lo; rd && paddr == 8'h28 && $past(cur_done[0], 2)
    |-> prdata == {24'h0, $past(conv_result[7:0], 2)}; endproperty
  a_cur_lo: assert property (p_cur_lo) else $error("bad low");
  c_err: cover property (pready && pslverr);
  c_rd: cover property (rd && !pslverr);
  c_wr: cover property (pready && pwrite && !pslverr);
endmodule : par_chk

// ==== sim/tb_top.sv ====
// Testbench for the result readout block
`timescale 1ns/10ps
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, lf = 32'h7678;
  logic [3:0]  cur_start = 0, cur_done = 0, temp_start = 0, temp_done = 0;
  logic [14:0] conv_result = 0;
  int          errors = 0, samples_checked = 0;
  always #25 pclk = ~pclk;
  par_readout par_readout_inst (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .cur_start   (cur_start),
    .cur_done    (cur_done),
    .temp_start  (temp_start),
    .temp_done   (temp_done),
    .conv_result (conv_result),
    .irq         (irq)
  );
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic test_done;
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
    int n = 0;
    @(posedge pclk);
    {cur_start, cur_done, temp_start, temp_done} <= 16'h0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready && ++n < 20);
    if (!pready) begin errors++; test_done(); end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic pr(logic [3:0] ev, int p, logic [7:0] a, logic [7:0] exp);
    @(posedge pclk);
    temp_done  <= 4'(ev[3]) << p;
    temp_start <= 4'(ev[2]) << p;
    cur_done   <= 4'(ev[1]) << p;
    cur_start  <= 4'(ev[0]) << p;
    apb(0, a + 8'(64 * p), 0);
    chk(rd, {24'h0, exp});
  endtask : pr
  initial begin
    int p;
    logic [14:0] r;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    pr(0, 0, 8'h30, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      r = (i == 7) ? 15'h7fff : lf[14:0];
      conv_result <= r;
      p = i % 4;
      pr(4'b0010, p, 8'h2c, {1'b1, r[14:8]});
      pr(4'b0010, p, 8'h28, r[7:0]);
      pr(4'b1000, p, 8'h34, {1'b1, r[14:8]});
      pr(4'b1000, p, 8'h30, r[7:0]);
      pr(4'b0100, p, 8'h34, {1'b0, r[14:8]});
      pr(0, p, 8'h2c, {1'b1, r[14:8]});
      pr(4'b0001, p, 8'h2c, {1'b0, r[14:8]});
    end
    pr(4'b0010, 1, 8'h2c, 8'hff);
    pr(0, 1, 8'h28, 8'hff);
    pr(0, 1, 8'h2c, 8'hff);
    pr(0, 3, 8'h34, 8'h7f);
    apb(1, 8'h2c, 8'hff);
    chk(err, 1);
    apb(0, 8'h00, 0);
    chk(err, 1);
    chk(irq, 0);
    apb(1, 8'h3c, 8'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1, 8'h38, 8'hff);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    test_done();
  end
endmodule : tb_top
bind par_readout par_chk #(.NPORT(NPORT)) par_chk_inst (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .cur_start   (cur_start),
  .cur_done    (cur_done),
  .temp_start  (temp_start),
  .temp_done   (temp_done),
  .conv_result (conv_result)
);
